// [core/scl_pkg.sv]
// Shared constants and types for the scaler control and status registers
package scl_pkg;
  // Timer stepping
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned STEP_NS       = 400;
  localparam logic [6:0]  STEP_CYCLES   = 7'(STEP_NS / CLK_PERIOD_NS);

  // Register offsets
  localparam logic [15:0] OFF_MEM_LAST  = 16'h0FFC;
  localparam logic [15:0] OFF_CNT_FIRST = 16'h1000;
  localparam logic [15:0] OFF_CNT_LAST  = 16'h107C;
  localparam logic [15:0] OFF_TEST_LA   = 16'h1090;
  localparam logic [15:0] OFF_TEST_LB   = 16'h1094;
  localparam logic [15:0] OFF_TEST_HA   = 16'h10A0;
  localparam logic [15:0] OFF_TEST_HB   = 16'h10A4;
  localparam logic [15:0] OFF_MASK      = 16'h1100;
  localparam logic [15:0] OFF_DWELL     = 16'h1104;
  localparam logic [15:0] OFF_CTRL      = 16'h1108;
  localparam logic [15:0] OFF_CTRL_SET  = 16'h110A;
  localparam logic [15:0] OFF_CTRL_CLR  = 16'h110C;
  localparam logic [15:0] OFF_STATUS    = 16'h110E;
  localparam logic [15:0] OFF_SLOT      = 16'h1110;
  localparam logic [15:0] OFF_IRQ_LEVEL = 16'h1112;
  localparam logic [15:0] OFF_AFULL     = 16'h112C;

  // Control field positions
  localparam int unsigned CTL_W     = 8;
  localparam int unsigned CTL_FMT   = 2;
  localparam int unsigned CTL_TEST  = 3;
  localparam int unsigned CTL_BERR  = 4;
  localparam int unsigned CTL_HDR   = 5;
  localparam int unsigned CTL_FLUSH = 6;
  localparam int unsigned CTL_AUTO  = 7;
  localparam logic [7:0]  CTL_RESET = 8'h00;

  // Status bit positions
  localparam int unsigned STS_HAS_DATA  = 0;
  localparam int unsigned STS_NEAR      = 1;
  localparam int unsigned STS_FULL      = 2;
  localparam int unsigned STS_CHAIN_RDY = 3;
  localparam int unsigned STS_CHAIN_OCC = 4;
  localparam int unsigned STS_TERM_IN   = 5;
  localparam int unsigned STS_TERM_OUT  = 6;
  localparam int unsigned STS_BERR_SEEN = 7;

  // Sizes and reset values
  localparam int unsigned CHANNELS    = 32;
  localparam int unsigned TERM_COUNT  = 4;
  localparam int unsigned SLOT_W      = 5;
  localparam int unsigned PIN_W       = CHANNELS + 4 + TERM_COUNT + SLOT_W;
  localparam int unsigned MEM_AW      = 15;
  localparam int unsigned MEM_DW      = 33;
  localparam logic [15:0] FULL_WORDS  = 16'(32768 - 33);
  localparam logic [15:0] AFULL_RESET = 16'h0040;
  localparam logic [4:0]  SLOT_RESET  = 5'h1F;
  localparam logic [2:0]  IRQ_RESET   = 3'h0;

  typedef enum logic [1:0] {
    SRC_OFF      = 2'b00,
    SRC_RANDOM   = 2'b01,
    SRC_PERIODIC = 2'b10
  } scl_src_t;

  typedef enum logic [1:0] {
    EV_IDLE = 2'b00,
    EV_HEAD = 2'b01,
    EV_DATA = 2'b10
  } scl_ev_state_t;
endpackage

// [core/scl_mem_if.sv]
// Port bundle between the register core and the event memory
`timescale 1ns/1ps
interface scl_mem_if;
  logic                        wr_en;
  logic [scl_pkg::MEM_AW-1:0]  wr_addr;
  logic [scl_pkg::MEM_DW-1:0]  wr_data;
  logic                        rd_en;
  logic [scl_pkg::MEM_AW-1:0]  rd_addr;
  logic [scl_pkg::MEM_DW-1:0]  rd_data;
  modport user  (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                 input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                 output rd_data);
endinterface

// [core/scl_event_store.sv]
// Event memory: one write port, one registered read port
`timescale 1ns/1ps
module scl_event_store (
  input wire logic sys_clk,
  scl_mem_if.store mem
);
  logic [scl_pkg::MEM_DW-1:0] words [2**scl_pkg::MEM_AW];

  always_ff @(posedge sys_clk) begin
    if (mem.wr_en) begin
      words[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (mem.rd_en) begin
      mem.rd_data <= words[mem.rd_addr];
    end
  end
endmodule

// [core/scl_pin_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module scl_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit moves only once the second and third stage agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      level <= '0;
    end else begin
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
  end
endmodule

// [core/scl_core.sv]
// Scaler control and status register bank with counters and event writer
// Notes on behaviour
// - Test mode: counter reads return test words
// - Mask bit n enables channel n
// - Disabled channels count but are not stored
// - Periodic trigger every dwell_count times 400 ns
// - Source select: off, random, periodic
// - Format 32 or 26 bit; optional header
// - Bus error only when allowed, else acknowledge
// - Front clear flushes memory when enabled
// - Optional counter zeroing after each trigger
// - Control zero after reset; bits 8-15 unused
// - Any control write clears counters and memory
// - Set alias sets bits written as one
// - Clear alias clears bits written as one
// - Data flag follows complete events or words
// - Near-limit flag at threshold, requests interrupt
// - Full at capacity minus 33 words
// - Chain flags show wired-OR backplane lines
// - Termination all-in and all-out flags
// - Bus error flag, cleared by status read
// - Slot code: pins or writable, write clears
// - Three-bit interrupt level, zero disables
// - Near-limit threshold resets to 64 words
`timescale 1ns/1ps
module scl_core #(
  parameter bit HAS_AUX_CONNECTOR = 1'b1
) (
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  input  wire logic                         bus_req,
  input  wire logic                         bus_write,
  input  wire logic [15:0]                  bus_addr,
  input  wire logic [31:0]                  bus_wdata,
  output logic                              bus_ack,
  output logic                              bus_berr,
  output logic      [31:0]                  bus_rdata,
  input  wire logic [scl_pkg::CHANNELS-1:0] channel_pulse,
  input  wire logic                         trigger_pin,
  input  wire logic                         front_clear,
  input  wire logic                         chain_ready_line,
  input  wire logic                         chain_occupied_line,
  input  wire logic [scl_pkg::TERM_COUNT-1:0] term_switch,
  input  wire logic [scl_pkg::SLOT_W-1:0]   slot_pins,
  output logic                              ready_drive,
  output logic                              busy_drive,
  output logic                              irq_request,
  output logic      [2:0]                   irq_level_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic is_mem(input logic [15:0] a);
    return a <= scl_pkg::OFF_MEM_LAST;
  endfunction

  function automatic logic is_cnt(input logic [15:0] a);
    return a >= scl_pkg::OFF_CNT_FIRST && a <= scl_pkg::OFF_CNT_LAST;
  endfunction

  function automatic logic [5:0] pop_count(input logic [31:0] m);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + 6'(m[i]);
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs
  logic [scl_pkg::PIN_W-1:0] pin_level;
  logic [31:0]               chan_q;
  logic [31:0]               chan_prev;
  logic                      trig_q;
  logic                      trig_prev;
  logic                      clear_q;
  logic                      clear_prev;
  logic                      trig_rise;
  logic                      clear_rise;
  logic [3:0]                term_q;
  logic [4:0]                slot_q;

  scl_pin_sync #(.WIDTH(scl_pkg::PIN_W)) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin     ({slot_pins, term_switch, chain_occupied_line,
               chain_ready_line, front_clear, trigger_pin, channel_pulse}),
    .level   (pin_level)
  );

  assign chan_q  = pin_level[31:0];
  assign trig_q  = pin_level[32];
  assign clear_q = pin_level[33];
  assign term_q  = pin_level[39:36];
  assign slot_q  = pin_level[44:40];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chan_prev  <= 32'h00000000;
      trig_prev  <= 1'b0;
      clear_prev <= 1'b0;
    end else begin
      chan_prev  <= chan_q;
      trig_prev  <= trig_q;
      clear_prev <= clear_q;
    end
  end

  assign trig_rise  = trig_q & ~trig_prev;
  assign clear_rise = clear_q & ~clear_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Bus request decode
  logic        mem_wait;
  logic        take;
  logic        wr_take;
  logic        rd_take;
  logic        ctrl_hit;
  logic        slot_wr;
  logic        module_clear;
  logic        mem_clear;
  logic        pop;
  logic [15:0] word_count;
  logic        mem_empty;

  logic [7:0]  ctrl;
  logic [31:0] chan_mask;
  logic [31:0] dwell;
  logic [15:0] test_la;
  logic [15:0] test_lb;
  logic [15:0] test_ha;
  logic [15:0] test_hb;
  logic [2:0]  irq_level;
  logic [15:0] afull_level;
  logic [4:0]  slot_reg;
  logic [4:0]  slot_now;
  scl_pkg::scl_src_t src;

  assign take     = bus_req & ~mem_wait;
  assign wr_take  = take & bus_write;
  assign rd_take  = take & ~bus_write;
  assign ctrl_hit = bus_addr == scl_pkg::OFF_CTRL
                 || bus_addr == scl_pkg::OFF_CTRL_SET
                 || bus_addr == scl_pkg::OFF_CTRL_CLR;
  assign slot_wr  = wr_take && bus_addr == scl_pkg::OFF_SLOT;
  assign module_clear = (wr_take & ctrl_hit)
                      | (slot_wr & ~HAS_AUX_CONNECTOR);
  assign mem_clear = module_clear | (clear_rise & ctrl[scl_pkg::CTL_FLUSH]);
  assign mem_empty = word_count == 16'h0000;
  assign pop       = rd_take & is_mem(bus_addr) & ~mem_empty;
  assign src       = scl_pkg::scl_src_t'(ctrl[1:0]);
  assign slot_now  = HAS_AUX_CONNECTOR ? slot_q : slot_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl        <= scl_pkg::CTL_RESET;
      chan_mask   <= 32'h00000000;
      dwell       <= 32'h00000000;
      test_la     <= 16'h0000;
      test_lb     <= 16'h0000;
      test_ha     <= 16'h0000;
      test_hb     <= 16'h0000;
      irq_level   <= scl_pkg::IRQ_RESET;
      afull_level <= scl_pkg::AFULL_RESET;
      slot_reg    <= scl_pkg::SLOT_RESET;
    end else if (wr_take) begin
      unique case (bus_addr)
        scl_pkg::OFF_CTRL:      ctrl <= bus_wdata[7:0];
        scl_pkg::OFF_CTRL_SET:  ctrl <= ctrl | bus_wdata[7:0];
        scl_pkg::OFF_CTRL_CLR:  ctrl <= ctrl & ~bus_wdata[7:0];
        scl_pkg::OFF_MASK:      chan_mask <= bus_wdata;
        scl_pkg::OFF_DWELL:     dwell <= bus_wdata;
        scl_pkg::OFF_TEST_LA:   test_la <= bus_wdata[15:0];
        scl_pkg::OFF_TEST_LB:   test_lb <= bus_wdata[15:0];
        scl_pkg::OFF_TEST_HA:   test_ha <= bus_wdata[15:0];
        scl_pkg::OFF_TEST_HB:   test_hb <= bus_wdata[15:0];
        scl_pkg::OFF_IRQ_LEVEL: irq_level <= bus_wdata[2:0];
        scl_pkg::OFF_AFULL:     afull_level <= bus_wdata[15:0];
        scl_pkg::OFF_SLOT: begin
          if (!HAS_AUX_CONNECTOR) begin
            slot_reg <= bus_wdata[4:0];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dwell timer
  logic [6:0]  pre_cnt;
  logic [31:0] step_cnt;
  logic        dwell_hit;

  always_ff @(posedge sys_clk) begin
    if (reset || src != scl_pkg::SRC_PERIODIC || module_clear) begin
      pre_cnt   <= 7'h00;
      step_cnt  <= 32'h00000000;
      dwell_hit <= 1'b0;
    end else if (pre_cnt == scl_pkg::STEP_CYCLES - 7'h01) begin
      pre_cnt <= 7'h00;
      if (dwell != 32'h00000000 && step_cnt + 32'h1 >= dwell) begin
        step_cnt  <= 32'h00000000;
        dwell_hit <= 1'b1;
      end else begin
        step_cnt  <= step_cnt + 32'h1;
        dwell_hit <= 1'b0;
      end
    end else begin
      pre_cnt   <= pre_cnt + 7'h01;
      dwell_hit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger acceptance and counters
  scl_pkg::scl_ev_state_t ev_state;
  logic        trig_fire;
  logic        accept;
  logic        cnt_clear;
  logic [31:0] trig_count;
  logic [31:0] cnt  [scl_pkg::CHANNELS];
  logic [31:0] snap [scl_pkg::CHANNELS];

  // Triggers arriving while an event is being written are dropped
  assign trig_fire = (src == scl_pkg::SRC_RANDOM && trig_rise)
                  || (src == scl_pkg::SRC_PERIODIC && dwell_hit);
  assign accept    = trig_fire && ev_state == scl_pkg::EV_IDLE
                  && !mem_clear;
  assign cnt_clear = module_clear | clear_rise
                   | (accept & ctrl[scl_pkg::CTL_AUTO]);

  for (genvar i = 0; i < scl_pkg::CHANNELS; i++) begin : g_chan
    // Counting ignores the mask; only storage honours it
    always_ff @(posedge sys_clk) begin
      if (reset || cnt_clear) begin
        cnt[i] <= 32'h00000000;
      end else if (chan_q[i] && !chan_prev[i]) begin
        cnt[i] <= cnt[i] + 32'h1;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (reset) begin
        snap[i] <= 32'h00000000;
      end else if (accept) begin
        snap[i] <= cnt[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || module_clear) begin
      trig_count <= 32'h00000000;
    end else if (accept) begin
      trig_count <= trig_count + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event writer
  scl_mem_if   mem ();
  logic [31:0] ev_mask;
  logic [4:0]  ev_ch;
  logic [1:0]  ev_src;
  logic [31:0] ev_rest;
  logic        ev_last;
  logic        full;
  logic        data_on;
  logic [14:0] wptr;
  logic [14:0] rptr;
  logic [31:0] data_word;

  assign full    = word_count >= scl_pkg::FULL_WORDS;
  assign ev_rest = ev_mask >> ev_ch;
  assign ev_last = ev_rest[31:1] == 31'h00000000;
  assign data_on = ev_state == scl_pkg::EV_DATA && ev_mask[ev_ch];
  assign data_word = ctrl[scl_pkg::CTL_FMT]
                   ? {ev_ch, 1'b0, snap[ev_ch][25:0]}
                   : snap[ev_ch];

  always_ff @(posedge sys_clk) begin
    if (reset || mem_clear) begin
      ev_state <= scl_pkg::EV_IDLE;
      ev_mask  <= 32'h00000000;
      ev_ch    <= 5'h00;
      ev_src   <= 2'b00;
    end else begin
      unique case (ev_state)
        scl_pkg::EV_IDLE: begin
          if (accept) begin
            ev_mask <= chan_mask;
            ev_src  <= ctrl[1:0];
            ev_ch   <= 5'h00;
            if (ctrl[scl_pkg::CTL_HDR]) begin
              ev_state <= scl_pkg::EV_HEAD;
            end else if (chan_mask != 32'h00000000) begin
              ev_state <= scl_pkg::EV_DATA;
            end
          end
        end
        scl_pkg::EV_HEAD: begin
          if (!full) begin
            ev_state <= ev_mask != 32'h00000000
                      ? scl_pkg::EV_DATA : scl_pkg::EV_IDLE;
          end
        end
        scl_pkg::EV_DATA: begin
          if (!(data_on && full)) begin
            if ((data_on && ev_last) || ev_ch == 5'h1F) begin
              ev_state <= scl_pkg::EV_IDLE;
            end
            ev_ch <= ev_ch + 5'h01;
          end
        end
        default: ev_state <= scl_pkg::EV_IDLE;
      endcase
    end
  end

  always_comb begin
    mem.wr_en   = !full && (ev_state == scl_pkg::EV_HEAD || data_on);
    mem.wr_addr = wptr;
    mem.wr_data = {data_on ? ev_last : ev_mask == 32'h00000000, data_word};
    if (ev_state == scl_pkg::EV_HEAD) begin
      mem.wr_data[31:0] = {slot_now, 1'b1, 2'b00, pop_count(ev_mask),
                           ev_src, trig_count[15:0]};
    end
    mem.rd_en   = pop;
    mem.rd_addr = rptr;
  end

  scl_event_store u_store (
    .sys_clk (sys_clk),
    .mem     (mem.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Memory occupancy
  logic [15:0] ev_stored;
  logic        has_data;
  logic        near;
  logic        pop_last;

  assign pop_last = mem_wait & mem.rd_data[32];

  always_ff @(posedge sys_clk) begin
    if (reset || mem_clear) begin
      wptr       <= 15'h0000;
      rptr       <= 15'h0000;
      word_count <= 16'h0000;
      ev_stored  <= 16'h0000;
    end else begin
      wptr       <= wptr + 15'(mem.wr_en);
      rptr       <= rptr + 15'(pop);
      word_count <= word_count + 16'(mem.wr_en) - 16'(pop);
      ev_stored  <= ev_stored + 16'(mem.wr_en & mem.wr_data[32])
                  - 16'(pop_last);
    end
  end

  assign has_data = ctrl[scl_pkg::CTL_HDR]
                  ? ev_stored != 16'h0000 : !mem_empty;
  assign near     = word_count >= afull_level;

  ////////////////////////////////////////////////////////////////////////////
  // Status and read data
  logic        berr_seen;
  logic        empty_berr;
  logic [7:0]  status;
  logic [31:0] reg_rdata;
  logic        mapped;

  assign empty_berr = rd_take & is_mem(bus_addr) & mem_empty
                    & ctrl[scl_pkg::CTL_BERR];

  always_ff @(posedge sys_clk) begin
    if (reset || empty_berr) begin
      berr_seen <= !reset;
    end else if (rd_take && bus_addr == scl_pkg::OFF_STATUS) begin
      berr_seen <= 1'b0;
    end
  end

  always_comb begin
    status = 8'h00;
    status[scl_pkg::STS_HAS_DATA]  = has_data;
    status[scl_pkg::STS_NEAR]      = near;
    status[scl_pkg::STS_FULL]      = full;
    status[scl_pkg::STS_CHAIN_RDY] = pin_level[34];
    status[scl_pkg::STS_CHAIN_OCC] = pin_level[35];
    status[scl_pkg::STS_TERM_IN]   = &term_q;
    status[scl_pkg::STS_TERM_OUT]  = ~|term_q;
    status[scl_pkg::STS_BERR_SEEN] = berr_seen;
  end

  always_comb begin
    reg_rdata = 32'h00000000;
    mapped    = 1'b1;
    if (is_cnt(bus_addr)) begin
      if (ctrl[scl_pkg::CTL_TEST]) begin
        reg_rdata = bus_addr[6] ? {test_hb, test_ha}
                                : {test_lb, test_la};
      end else begin
        reg_rdata = cnt[bus_addr[6:2]];
      end
    end else begin
      unique case (bus_addr)
        scl_pkg::OFF_TEST_LA:   reg_rdata = {16'h0000, test_la};
        scl_pkg::OFF_TEST_LB:   reg_rdata = {16'h0000, test_lb};
        scl_pkg::OFF_TEST_HA:   reg_rdata = {16'h0000, test_ha};
        scl_pkg::OFF_TEST_HB:   reg_rdata = {16'h0000, test_hb};
        scl_pkg::OFF_MASK:      reg_rdata = chan_mask;
        scl_pkg::OFF_DWELL:     reg_rdata = dwell;
        scl_pkg::OFF_CTRL:      reg_rdata = {24'h000000, ctrl};
        scl_pkg::OFF_CTRL_SET:  reg_rdata = 32'h00000000;
        scl_pkg::OFF_CTRL_CLR:  reg_rdata = 32'h00000000;
        scl_pkg::OFF_STATUS:    reg_rdata = {24'h000000, status};
        scl_pkg::OFF_SLOT:      reg_rdata = {27'h0000000, slot_now};
        scl_pkg::OFF_IRQ_LEVEL: reg_rdata = {29'h00000000, irq_level};
        scl_pkg::OFF_AFULL:     reg_rdata = {16'h0000, afull_level};
        default:                mapped = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_wait <= 1'b0;
    end else begin
      mem_wait <= pop;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_ack   <= 1'b0;
      bus_berr  <= 1'b0;
      bus_rdata <= 32'h00000000;
    end else begin
      bus_ack  <= 1'b0;
      bus_berr <= 1'b0;
      if (mem_wait) begin
        bus_ack   <= 1'b1;
        bus_rdata <= mem.rd_data[31:0];
      end else if (rd_take && is_mem(bus_addr)) begin
        if (mem_empty) begin
          bus_berr  <= ctrl[scl_pkg::CTL_BERR];
          bus_ack   <= !ctrl[scl_pkg::CTL_BERR];
          bus_rdata <= 32'h00000000;
        end
      end else if (take && mapped && !(slot_wr && HAS_AUX_CONNECTOR)) begin
        // Aux variant leaves slot writes unanswered so the bus times out
        bus_ack   <= 1'b1;
        bus_rdata <= bus_write ? 32'h00000000 : reg_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Backplane outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ready_drive   <= 1'b0;
      busy_drive    <= 1'b0;
      irq_request   <= 1'b0;
      irq_level_out <= 3'h0;
    end else begin
      ready_drive   <= has_data;
      busy_drive    <= ev_state != scl_pkg::EV_IDLE;
      irq_request   <= near && irq_level != 3'h0;
      irq_level_out <= irq_level;
    end
  end
endmodule

// [bench/scl_core_props.sv]
// Port checker for the scaler register bank
`timescale 1ns/1ps
module scl_core_props #(
  parameter bit HAS_AUX_CONNECTOR = 1'b1
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        bus_req,
  input wire logic        bus_write,
  input wire logic [15:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_ack,
  input wire logic        bus_berr,
  input wire logic [31:0] bus_rdata,
  input wire logic        irq_request,
  input wire logic [2:0]  irq_level_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // A request right after a memory read that pops a word is refused
  wire mem_rd = bus_req && !bus_write && bus_addr < 16'h1000;
  wire wr     = bus_req && bus_write;
  a_ack_berr_excl:
    assert property (!(bus_ack && bus_berr)) else $error("ack with berr");
  a_berr_mem_only:
    assert property (bus_berr |-> $past(mem_rd)) else $error("stray berr");
  a_reset_quiet:
    assert property ($fell(reset) |-> !bus_ack && !irq_request &&
      irq_level_out == 3'h0) else $error("output after reset");
  a_ctrl_write_ack:
    assert property (wr && bus_addr == 16'h1108 && !$past(mem_rd)
      |=> bus_ack && bus_rdata == 32'h0) else $error("control write");
  a_mask_write_ack:
    assert property (wr && bus_addr == 16'h1100 && !$past(mem_rd)
      |-> ##1 bus_ack && !bus_berr) else $error("mask write");
  a_slot_write_mute:
    assert property (HAS_AUX_CONNECTOR && wr && bus_addr == 16'h1110 &&
      !$past(mem_rd) |=> !bus_ack && !bus_berr) else $error("slot write");
  a_irq_level_copy:
    assert property (wr && bus_addr == 16'h1112 && !$past(mem_rd) |=> ##1
      irq_level_out == 3'($past(bus_wdata, 2))) else $error("irq level");
  a_irq_off_zero:
    assert property (irq_level_out == 3'h0 && $past(irq_level_out) == 3'h0
      |-> !irq_request) else $error("irq at level 0");
  c_berr: cover property (bus_berr);
  c_mem_ack: cover property (mem_rd ##2 bus_ack);
  c_irq_level: cover property (irq_level_out != 3'h0);
endmodule
bind scl_core scl_core_props #(.HAS_AUX_CONNECTOR(HAS_AUX_CONNECTOR))
  scl_core_props_inst (.sys_clk, .reset, .bus_req, .bus_write, .bus_addr,
  .bus_wdata, .bus_ack, .bus_berr, .bus_rdata, .irq_request, .irq_level_out);

// [bench/scl_chain_model.sv]
// Chain neighbours and backplane pins seen by the status logic
`timescale 1ns/1ps
module scl_chain_model (
  input  wire logic [1:0] mode,
  output logic            ready_line,
  output logic            occupied_line,
  output logic [3:0]      term_switch,
  output logic [4:0]      slot_pins
);
  assign ready_line    = mode == 2'h0;
  assign occupied_line = mode != 2'h0;
  assign term_switch   = mode == 2'h0 ? 4'hF : {2{mode[0], 1'b0}};
  // Slot code value is arbitrary
  assign slot_pins     = 5'h0B;
endmodule

// [bench/tb.sv]
// Register-level testbench for the scaler status bank
`timescale 1ns/1ps
module tb;
  logic        sys_clk = 0, reset = 1, bus_req = 0, bus_write = 0;
  logic        bus_ack, bus_berr, ready_line, occupied_line;
  logic        ready_drive, busy_drive, trigger_pin = 0, front_clear = 0;
  logic [1:0]  mode = 0, ans;
  logic [3:0]  term_switch;
  logic [4:0]  slot_pins;
  logic [15:0] bus_addr = 0;
  logic [31:0] bus_wdata = 0, bus_rdata, channel_pulse = 0;
  int          failures = 0, checked = 0;
  scl_core scl_core_inst (.sys_clk, .reset, .bus_req, .bus_write, .bus_addr,
    .bus_wdata, .bus_ack, .bus_berr, .bus_rdata, .channel_pulse,
    .trigger_pin, .front_clear, .chain_ready_line(ready_line),
    .chain_occupied_line(occupied_line), .term_switch, .slot_pins,
    .ready_drive, .busy_drive, .irq_request(), .irq_level_out());
  scl_chain_model scl_chain_model_inst (.mode, .ready_line, .occupied_line,
    .term_switch, .slot_pins);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(logic [31:0] s, e, string n);
    checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request drops after its edge, else it would be taken again
  task automatic op(logic w, logic [15:0] a, logic [31:0] d, e,
                    logic [1:0] ea);
    @(negedge sys_clk);
    {bus_req, bus_write, bus_addr, bus_wdata} = {1'b1, w, a, d};
    @(negedge sys_clk);
    bus_req = 0;
    ans = {bus_berr, bus_ack};
    for (int i = 0; i < 3 && ans == 2'h0; i++) begin
      @(negedge sys_clk);
      ans = {bus_berr, bus_ack};
    end
    chk(32'(ans), 32'(ea), $sformatf("answer %h", a));
    if (ea == 2'h1) chk(bus_rdata, e, $sformatf("data %h", a));
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] e);
    op(1'b0, a, 32'h0, e, 2'h1);
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    op(1'b1, a, d, 32'h0, 2'h1);
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    reset = 0;
    rd(16'h1108, 32'h0);
    rd(16'h112C, 32'h40);
    rd(16'h1110, 32'hB);
    op(1'b1, 16'h1110, 32'h1, 32'h0, 2'h0);
    op(1'b1, 16'h1200, 32'h1, 32'h0, 2'h0);
    rd(16'h1112, 32'h0);
    wr(16'h1112, 32'h5);
    rd(16'h1112, 32'h5);
    $display("reset test end");
    wr(16'h1108, 32'hFFFF);
    rd(16'h1108, 32'hFF);
    wr(16'h110C, 32'h10);
    rd(16'h1108, 32'hEF);
    wr(16'h110A, 32'h10);
    rd(16'h1108, 32'hFF);
    for (int i = 0; i < 4; i++)
      wr(16'h1090 + 16'({i[1], 1'b0, i[0], 2'h0}),
         32'h1111 * (i + 1));
    for (int c = 0; c < 32; c++)
      rd(16'h1000 + 16'(4 * c), c[4] ? 32'h44443333 : 32'h22221111);
    $display("control test end");
    wr(16'h1100, 32'h1);
    rd(16'h1100, 32'h1);
    wr(16'h1104, 32'h2);
    wr(16'h1108, 32'h12);
    // Two dwell steps are 160 cycles: one status read before, one after
    repeat (125) @(negedge sys_clk);
    rd(16'h110E, 32'h28);
    repeat (45) @(negedge sys_clk);
    rd(16'h110E, 32'h29);
    rd(16'h0000, 32'h0);
    op(1'b0, 16'h0000, 32'h0, 32'h0, 2'h2);
    rd(16'h110E, 32'hA8);
    rd(16'h110E, 32'h28);
    wr(16'h110C, 32'h12);
    $display("trigger test end");
    wr(16'h1100, 32'h2);
    wr(16'h1108, 32'hA1);
    repeat (3) begin
      channel_pulse = 32'h3;
      repeat (4) @(negedge sys_clk);
      channel_pulse = 32'h0;
      repeat (4) @(negedge sys_clk);
    end
    rd(16'h1000, 32'h3);
    trigger_pin = 1;
    repeat (6) @(negedge sys_clk);
    trigger_pin = 0;
    rd(16'h1004, 32'h0);
    // Flush bit is off, so the stored event must survive the clear
    front_clear = 1;
    repeat (6) @(negedge sys_clk);
    front_clear = 0;
    chk(32'({ready_drive, busy_drive}), 32'h2, "drives");
    rd(16'h110E, 32'h29);
    rd(16'h0000, 32'h5C050001);
    rd(16'h0000, 32'h3);
    rd(16'h110E, 32'h28);
    $display("event test end");
    for (int m = 1; m < 3; m++) begin
      mode = 2'(m);
      repeat (6) @(negedge sys_clk);
      rd(16'h110E, m == 1 ? 32'h10 : 32'h50);
    end
    $display("chain test end");
    test_done();
  end
endmodule
